// File: hdl/cpu_regfile_stack_irq.sv
// Register file, pointers, stack pointer and interrupt entry sequencing
`timescale 1ns/10ps
module cpu_regfile_stack_irq import cpu_core_pkg::*; #(
  parameter int IRQ_N = 8,
  parameter logic [IRQ_N-1:0] LEVEL_MASK = '0,
  parameter logic [PC_W-1:0] BOOT_START = 12'hc00,
  parameter logic [PC_W-1:0] VEC_STEP = 12'h001
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Operand reads
  input wire logic [REG_AW-1:0] rd_a_addr,
  input wire logic [REG_AW-1:0] rd_b_addr,
  input wire logic rd_wide,
  output logic [DATA_W-1:0] rd_a_data_r,
  output logic [DATA_W-1:0] rd_b_data_r,
  // Result write
  input wire logic wr_en,
  input wire logic wr_wide,
  input wire logic [REG_AW-1:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_data,
  // Data-space access to the register window
  input wire logic [WORD_W-1:0] ds_addr,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic [DATA_W-1:0] ds_wdata,
  output logic ds_hit_r,
  output logic [DATA_W-1:0] ds_rdata_r,
  // Pointer addressing
  input wire logic ptr_go,
  input wire ptr_sel_t ptr_sel,
  input wire am_t ptr_mode,
  input wire logic [5:0] ptr_disp,
  output logic [WORD_W-1:0] ptr_addr_r,
  // Stack operations and stack pointer I/O registers
  input wire sop_t stack_op,
  input wire logic [DATA_W-1:0] push_data,
  input wire logic [PC_W-1:0] ret_pc,
  input wire logic sp_low_wr,
  input wire logic sp_high_wr,
  input wire logic [DATA_W-1:0] sp_wdata,
  output logic [DATA_W-1:0] stack_pointer_low,
  output logic [DATA_W-1:0] stack_pointer_high,
  // Stack SRAM requests
  output logic stk_we_r,
  output logic stk_rd_r,
  output logic [WORD_W-1:0] stk_addr_r,
  output logic [DATA_W-1:0] stk_wdata_r,
  // Interrupt sources and controls
  input wire logic [IRQ_N-1:0] irq_event,
  input wire logic [IRQ_N-1:0] irq_level,
  input wire logic [IRQ_N-1:0] irq_en,
  input wire logic flag_clr_wr,
  input wire logic [IRQ_N-1:0] flag_clr_mask,
  input wire logic insn_done,
  input wire logic sei,
  input wire logic cli,
  input wire logic return_from_interrupt,
  input wire logic status_register_i_wr,
  input wire logic status_register_i_wdata,
  input wire logic vector_select_bit,
  input wire logic boot_lock_bit_app,
  input wire logic boot_lock_bit_boot,
  input wire logic pc_in_boot,
  // Interrupt results
  output logic gie_r,
  output logic [IRQ_N-1:0] irq_flags_r,
  output logic irq_busy_r,
  output logic vec_valid_r,
  output logic [PC_W-1:0] vec_addr_r
);

  localparam int IW = $clog2(IRQ_N);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Lowest index pending wins: lower vector, higher priority
  function automatic logic [IW-1:0] first_set(input logic [IRQ_N-1:0] v);
    first_set = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (v[i]) first_set = IW'(i);
    end
  endfunction : first_set

  // Source k sits k+1 steps above the reset vector of its base
  function automatic logic [PC_W-1:0] vec_of(input logic [IW-1:0] k,
                                            input logic vsel);
    logic [PC_W-1:0] base;
    base = vsel ? BOOT_START : VEC_RESET;
    vec_of = base + PC_W'((PC_W'(k) + 12'h001) * VEC_STEP);
  endfunction : vec_of

  ////////////////////////////////////////////////////////////////////////////
  // Register file hookup
  // No clock divider anywhere: everything runs on clk itself
  wire ds_hit = ds_addr < REGFILE_END;
  wire ds_wr_hit = ds_wr && ds_hit && !wr_en;
  wire [REG_AW-1:0] ra = rd_wide ? {rd_a_addr[4:1], 1'b0} : rd_a_addr;
  wire [REG_AW-1:0] rb = rd_wide ? {rd_a_addr[4:1], 1'b1} : rd_b_addr;
  wire gw_en = wr_en || ds_wr_hit;
  wire [REG_AW-1:0] gw_addr = wr_en ? wr_addr : ds_addr[REG_AW-1:0];
  wire [WORD_W-1:0] gw_data = wr_en ? wr_data : {8'h00, ds_wdata};
  wire [DATA_W-1:0] ra_data, rb_data, dsr_data;
  wire [WORD_W-1:0] pval;

  // Pointer effective address and write-back
  wire [WORD_W-1:0] ptr_inc = pval + PTR_ONE;
  wire [WORD_W-1:0] ptr_dec = pval - PTR_ONE;
  wire [WORD_W-1:0] ptr_ea = (ptr_mode == AM_DISP) ? pval + {10'h000, ptr_disp}
                           : (ptr_mode == AM_PREDEC) ? ptr_dec : pval;
  wire ptr_we = ptr_go && (ptr_mode == AM_POSTINC || ptr_mode == AM_PREDEC);
  wire [WORD_W-1:0] ptr_new = (ptr_mode == AM_PREDEC) ? ptr_dec : ptr_inc;

  regfile_core u_regs (
    .clk(clk),
    .nrst(nrst),
    .ra_addr(ra),
    .rb_addr(rb),
    .dsr_addr(ds_addr[REG_AW-1:0]),
    .ra_data(ra_data),
    .rb_data(rb_data),
    .dsr_data(dsr_data),
    .we(gw_en),
    .we_wide(wr_en && wr_wide),
    .waddr(gw_addr),
    .wdata(gw_data),
    .pwe(ptr_we),
    .psel(ptr_sel),
    .pdata(ptr_new),
    .pval(pval)
  );

  // Operand, data-space and pointer outputs
  always_ff @(posedge clk) begin
    rd_a_data_r <= nrst ? ra_data : REG_RESET;
    rd_b_data_r <= nrst ? rb_data : REG_RESET;
    ds_hit_r <= nrst && (ds_rd || ds_wr) && ds_hit;
    ds_rdata_r <= !nrst ? REG_RESET : (ds_rd && ds_hit) ? dsr_data
                : ds_rdata_r;
    ptr_addr_r <= !nrst ? '0 : ptr_go ? ptr_ea : ptr_addr_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt qualification
  wire [IRQ_N-1:0] req = ((irq_flags_r & ~LEVEL_MASK)
                        | (irq_level & LEVEL_MASK)) & irq_en;
  // Boot locks keep interrupts out of the locked section's code
  wire suppress = (boot_lock_bit_app && !pc_in_boot && vector_select_bit)
               || (boot_lock_bit_boot && pc_in_boot && !vector_select_bit);
  seq_state_t state_r, state_nxt;
  wire idle = state_r == ST_IDLE;
  // Sei, return_from_interrupt and cli boundaries never take: the next instruction runs first
  wire take = insn_done && idle && stack_op == SOP_NONE && gie_r && !cli
           && !sei && !return_from_interrupt && !status_register_i_wr && !suppress
           && (req != '0);
  wire [IW-1:0] take_idx = first_set(req);
  wire [IRQ_N-1:0] take_clr = take ? (IRQ_N'(1) << take_idx) : '0;
  wire [IRQ_N-1:0] w1c = flag_clr_wr ? flag_clr_mask : '0;
  // A new event beats both clears in the same cycle
  wire [IRQ_N-1:0] flags_nxt = ((irq_flags_r & ~w1c & ~take_clr)
                              | irq_event) & ~LEVEL_MASK;
  // Global enable; only the I bit is kept here, other flags untouched
  wire gie_nxt = take ? 1'b0 : cli ? 1'b0 : (sei || return_from_interrupt) ? 1'b1
               : status_register_i_wr ? status_register_i_wdata : gie_r;

  ////////////////////////////////////////////////////////////////////////////
  // Return-address push sequencer and stack pointer
  logic [SP_W-1:0] sp_r, sp_nxt;
  logic [PC_W-1:0] pc_hold_r, vec_hold_r;
  logic entry_r;
  wire start_call = idle && stack_op == SOP_CALL;
  wire pushing = state_r == ST_PUSH_LO || state_r == ST_PUSH_HI;
  wire pop1 = idle && stack_op == SOP_POP;
  wire pop2 = idle && (stack_op == SOP_RET || return_from_interrupt);
  wire push1 = idle && stack_op == SOP_PUSH;

  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = (take || start_call) ? ST_PUSH_LO : ST_IDLE;
      ST_PUSH_LO: state_nxt = ST_PUSH_HI;
      ST_PUSH_HI: state_nxt = entry_r ? ST_VECT : ST_IDLE;
      ST_VECT: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Register writes only while no return address is in flight
  always_comb begin
    if (pushing) sp_nxt = sp_r - SP_ONE;
    else if (!idle) sp_nxt = sp_r;
    else if (sp_low_wr) sp_nxt = {sp_r[9:8], sp_wdata};
    else if (sp_high_wr) sp_nxt = {sp_wdata[1:0], sp_r[7:0]};
    else if (push1) sp_nxt = sp_r - SP_ONE;
    else if (pop1) sp_nxt = sp_r + SP_ONE;
    else if (pop2) sp_nxt = sp_r + SP_TWO;
    else sp_nxt = sp_r;
  end

  // Reset puts the stack at TOP_OF_RAM, 0x2ff, already above 0x100
  assign stack_pointer_low = sp_r[7:0];
  assign stack_pointer_high = {6'h00, sp_r[9:8]};

  // Byte pushed this cycle: return address low then high, or push data
  wire [DATA_W-1:0] push_byte = (state_r == ST_PUSH_LO) ? pc_hold_r[7:0]
                              : (state_r == ST_PUSH_HI)
                              ? {4'h0, pc_hold_r[11:8]} : push_data;

  // Sequencer and pointer state
  always_ff @(posedge clk) begin
    state_r <= nrst ? state_nxt : ST_IDLE;
    sp_r <= nrst ? sp_nxt : TOP_OF_RAM;
    entry_r <= !nrst ? 1'b0 : idle ? take : entry_r;
    pc_hold_r <= !nrst ? '0 : (take || start_call) ? ret_pc : pc_hold_r;
    vec_hold_r <= !nrst ? '0 : take ? vec_of(take_idx, vector_select_bit)
                : vec_hold_r;
  end

  // Stack SRAM request outputs
  always_ff @(posedge clk) begin
    stk_we_r <= nrst && (pushing || push1);
    stk_rd_r <= nrst && (pop1 || pop2);
    stk_addr_r <= !nrst ? '0 : (pop1 || pop2) ? {6'h00, sp_r + SP_ONE}
                : {6'h00, sp_r};
    stk_wdata_r <= nrst ? push_byte : REG_RESET;
  end

  // Interrupt outputs
  always_ff @(posedge clk) begin
    gie_r <= nrst && gie_nxt;
    irq_flags_r <= nrst ? flags_nxt : '0;
    irq_busy_r <= nrst && state_nxt != ST_IDLE;
    vec_valid_r <= nrst && state_r == ST_VECT;
    vec_addr_r <= !nrst ? VEC_RESET : (state_r == ST_VECT) ? vec_hold_r
                : vec_addr_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence two_pushes_s;
    stk_we_r ##1 stk_we_r;
  endsequence

  entry_timing_a: assert property (
    take |-> ##2 two_pushes_s ##1 vec_valid_r)
    else $error("interrupt entry not four cycles with two pushes");

  // Measured from the cycle after take, so a same-cycle SP write is allowed
  entry_sp_a: assert property (
    take |-> ##3 (sp_r == $past(sp_r, 2) - SP_TWO))
    else $error("entry did not lower stack pointer by two");

  push_one_a: assert property (
    (push1 && !sp_low_wr && !sp_high_wr) |=>
      (sp_r == $past(sp_r) - SP_ONE) && stk_addr_r[9:0] == $past(sp_r))
    else $error("push did not store then decrement");

  pop_two_a: assert property (
    (pop2 && !pop1 && !sp_low_wr && !sp_high_wr) |=>
      sp_r == $past(sp_r) + SP_TWO)
    else $error("return did not raise stack pointer by two");

  take_qual_a: assert property (
    take |-> gie_r && irq_en[take_idx]
      && (LEVEL_MASK[take_idx] ? irq_level[take_idx] : irq_flags_r[take_idx]))
    else $error("interrupt taken without both enables");

  gie_cycle_a: assert property (
    take |=> !gie_r ##3 !gie_r || $past(sei) || $past(return_from_interrupt))
    else $error("global enable not cleared on entry");

  return_from_interrupt_gie_a: assert property (
    return_from_interrupt && !cli |=> gie_r)
    else $error("return from interrupt did not set global enable");

  cli_block_a: assert property (
    cli |-> !take ##1 !gie_r)
    else $error("interrupt served despite clear-global");

  flag_vec_a: assert property (
    take && !LEVEL_MASK[take_idx] && !irq_event[take_idx] |=>
      !irq_flags_r[$past(take_idx)])
    else $error("flag not cleared when vectoring");

  flag_hold_a: assert property (
    (irq_event != '0) |=> ((irq_flags_r & $past(irq_event & ~LEVEL_MASK))
      == $past(irq_event & ~LEVEL_MASK)))
    else $error("interrupt event did not set its flag");

  sph_zero_a: assert property (
    sp_high_wr && idle |=> stack_pointer_high[7:2] == 6'h00
      && ($past(sp_low_wr)
        || stack_pointer_high[1:0] == $past(sp_wdata[1:0])))
    else $error("unused stack pointer bits not zero");

endmodule : cpu_regfile_stack_irq

// File: pkg/cpu_core_pkg.sv
// Shared constants and types for the register file, stack and interrupt core
package cpu_core_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register file geometry
  localparam int REG_COUNT = 32;
  localparam int REG_AW = 5;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam logic [4:0] PTR_BASE = 5'h1a;
  localparam logic [15:0] REGFILE_END = 16'h0020;
  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer and program counter
  localparam int SP_W = 10;
  localparam int PC_W = 12;
  localparam logic [SP_W-1:0] TOP_OF_RAM = 10'h2ff;
  localparam logic [SP_W-1:0] SP_ONE = 10'h001;
  localparam logic [SP_W-1:0] SP_TWO = 10'h002;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  localparam logic [PC_W-1:0] VEC_RESET = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer selection and addressing modes
  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } ptr_sel_t;

  typedef enum logic [1:0] {
    AM_PLAIN = 2'h0,
    AM_DISP = 2'h1,
    AM_POSTINC = 2'h2,
    AM_PREDEC = 2'h3
  } am_t;

  // Stack operations requested by the instruction in execution
  typedef enum logic [2:0] {
    SOP_NONE = 3'h0,
    SOP_PUSH = 3'h1,
    SOP_POP = 3'h2,
    SOP_CALL = 3'h3,
    SOP_RET = 3'h4
  } sop_t;

  // Return-address push sequencer, Gray coded along the entry path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH_LO = 2'b01,
    ST_PUSH_HI = 2'b11,
    ST_VECT = 2'b10
  } seq_state_t;

endpackage : cpu_core_pkg

// File: hdl/regfile_core.sv
// 32 x 8 working register file with general and pointer write ports
`timescale 1ns/10ps
module regfile_core import cpu_core_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Read ports, all see writes of the same cycle
  input wire logic [REG_AW-1:0] ra_addr,
  input wire logic [REG_AW-1:0] rb_addr,
  input wire logic [REG_AW-1:0] dsr_addr,
  output logic [DATA_W-1:0] ra_data,
  output logic [DATA_W-1:0] rb_data,
  output logic [DATA_W-1:0] dsr_data,
  // General write port, 8 or 16 bits
  input wire logic we,
  input wire logic we_wide,
  input wire logic [REG_AW-1:0] waddr,
  input wire logic [WORD_W-1:0] wdata,
  // Pointer write port and selected pointer value
  input wire logic pwe,
  input wire ptr_sel_t psel,
  input wire logic [WORD_W-1:0] pdata,
  output logic [WORD_W-1:0] pval
);

  ////////////////////////////////////////////////////////////////////////////
  // Low byte of a pointer sits at the even register of its pair
  function automatic logic [REG_AW-1:0] ptr_lo(input ptr_sel_t s);
    ptr_lo = PTR_BASE + {2'b00, s, 1'b0};
  endfunction : ptr_lo

  logic [DATA_W-1:0] mem_r [REG_COUNT];
  logic [DATA_W-1:0] mem_nxt [REG_COUNT];
  wire [REG_AW-1:0] w_lo = {waddr[REG_AW-1:1], 1'b0};
  wire [REG_AW-1:0] w_hi = {waddr[REG_AW-1:1], 1'b1};
  wire [REG_AW-1:0] p_lo = ptr_lo(psel);
  wire [REG_AW-1:0] p_hi = p_lo + 5'h01;

  // Next contents; pointer update wins on overlap
  always_comb begin
    mem_nxt = mem_r;
    if (we && we_wide) begin
      mem_nxt[w_lo] = wdata[7:0];
      mem_nxt[w_hi] = wdata[15:8];
    end else if (we) begin
      mem_nxt[waddr] = wdata[7:0];
    end
    if (pwe) begin
      mem_nxt[p_lo] = pdata[7:0];
      mem_nxt[p_hi] = pdata[15:8];
    end
  end

  // Port reads come from the next state, so a result is forwarded at once; pval comes from the current state
  assign ra_data = mem_nxt[ra_addr];
  assign rb_data = mem_nxt[rb_addr];
  assign dsr_data = mem_nxt[dsr_addr];
  assign pval = {mem_r[p_hi], mem_r[p_lo]};

  // Storage
  always_ff @(posedge clk) begin
    for (int i = 0; i < REG_COUNT; i++) begin
      mem_r[i] <= nrst ? mem_nxt[i] : REG_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ptr_pair_a: assert property (@(posedge clk) disable iff (!nrst)
    pwe |=> {mem_r[ptr_lo($past(psel)) + 5'h01], mem_r[ptr_lo($past(psel))]}
      == $past(pdata))
    else $error("pointer pair not written low even, high odd");

  wide_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (we && we_wide && !pwe) |=>
      {mem_r[{$past(waddr[4:1]), 1'b1}], mem_r[{$past(waddr[4:1]), 1'b0}]}
      == $past(wdata))
    else $error("16-bit result not stored in register pair");

endmodule : regfile_core

// File: testbench/stack_sram_model.sv
// Behavioural data SRAM holding the stack, on the far side of the core
`timescale 1ns/10ps
module stack_sram_model (
  // Clock
  input wire logic clk,
  // Stack requests from the core
  input wire logic we,
  input wire logic rd,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  // Read data, valid only in the cycle after a read request
  output logic [7:0] rdata_r
);
  logic [7:0] mem [0:1023];

  ////////////////////////////////////////////////////////////
  // Idle data toggles so a stale byte never passes for a read
  initial begin
    rdata_r = 8'h5a;
  end
  always @(posedge clk) begin
    if (we) begin
      mem[addr[9:0]] <= wdata;
    end
    if (rd) begin
      rdata_r <= mem[addr[9:0]];
    end else begin
      rdata_r <= ~rdata_r;
    end
  end
endmodule : stack_sram_model

// File: testbench/cpu_regfile_stack_irq_tb.sv
// Self-checking bench for register file, stack and interrupt entry
`timescale 1ns/10ps
module cpu_regfile_stack_irq_tb import cpu_core_pkg::*;;
  // Design inputs, all given a value at time zero
  logic clk = 1'b0, nrst = 1'b0;
  logic [4:0] rd_a_addr = 5'h00, rd_b_addr = 5'h00, wr_addr = 5'h00;
  logic rd_wide = 1'b0, wr_en = 1'b0, wr_wide = 1'b0, ds_rd = 1'b0;
  logic ds_wr = 1'b0, ptr_go = 1'b0, sp_low_wr = 1'b0, sp_high_wr = 1'b0;
  logic [15:0] wr_data = 16'h0000, ds_addr = 16'h0000;
  logic [7:0] ds_wdata = 8'h00, push_data = 8'h00, sp_wdata = 8'h00;
  logic [5:0] ptr_disp = 6'h00;
  logic [11:0] ret_pc = 12'h123;
  ptr_sel_t ptr_sel = PTR_Z;
  am_t ptr_mode = AM_PLAIN;
  sop_t stack_op = SOP_NONE;
  logic [7:0] irq_event = 8'h00, irq_level = 8'h00, irq_en = 8'hff;
  logic [7:0] flag_clr_mask = 8'h00;
  logic flag_clr_wr = 1'b0, insn_done = 1'b0, sei = 1'b0, cli = 1'b0;
  logic return_from_interrupt = 1'b0, status_register_i_wr = 1'b0, status_register_i_wdata = 1'b0;
  logic vector_select_bit = 1'b0, boot_lock_bit_app = 1'b0;
  logic boot_lock_bit_boot = 1'b0, pc_in_boot = 1'b0;
  // Design outputs and partner read data
  logic [7:0] rd_a_data_r, rd_b_data_r, ds_rdata_r, stack_pointer_low;
  logic [7:0] stack_pointer_high, stk_wdata_r, sram_rdata, irq_flags_r;
  logic [15:0] ptr_addr_r, stk_addr_r;
  logic ds_hit_r, stk_we_r, stk_rd_r, gie_r, irq_busy_r, vec_valid_r;
  logic [11:0] vec_addr_r;
  int n_errors = 0;
  int n_compared = 0;

  // One level-type source on the top index, the rest flag-type
  cpu_regfile_stack_irq #(.LEVEL_MASK(8'h80)) cpu_regfile_stack_irq_inst (
    .clk, .nrst, .rd_a_addr, .rd_b_addr, .rd_wide, .rd_a_data_r,
    .rd_b_data_r, .wr_en, .wr_wide, .wr_addr, .wr_data, .ds_addr, .ds_rd,
    .ds_wr, .ds_wdata, .ds_hit_r, .ds_rdata_r, .ptr_go, .ptr_sel, .ptr_mode,
    .ptr_disp, .ptr_addr_r, .stack_op, .push_data, .ret_pc, .sp_low_wr,
    .sp_high_wr, .sp_wdata, .stack_pointer_low, .stack_pointer_high,
    .stk_we_r, .stk_rd_r, .stk_addr_r, .stk_wdata_r, .irq_event, .irq_level,
    .irq_en, .flag_clr_wr, .flag_clr_mask, .insn_done, .sei, .cli, .return_from_interrupt,
    .status_register_i_wr, .status_register_i_wdata, .vector_select_bit, .boot_lock_bit_app,
    .boot_lock_bit_boot, .pc_in_boot, .gie_r, .irq_flags_r, .irq_busy_r,
    .vec_valid_r, .vec_addr_r);

  stack_sram_model stack_sram_model_inst (.clk(clk), .we(stk_we_r),
    .rd(stk_rd_r), .addr(stk_addr_r), .wdata(stk_wdata_r),
    .rdata_r(sram_rdata));

  initial begin
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  // Shared helpers: compare, step to the next falling edge
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task tick();
    @(negedge clk);
  endtask : tick

  task wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Cycles 2 and 3 of a return-address push, low byte at the higher address
  task ret_push(input logic [11:0] pc, input logic [15:0] sp);
    tick();
    chk("we_lo", stk_we_r, 16'h0001);
    chk("lo", stk_wdata_r, {8'h00, pc[7:0]});
    chk("lo_addr", stk_addr_r, sp);
    tick();
    chk("hi", stk_wdata_r, {12'h000, pc[11:8]});
    chk("hi_addr", stk_addr_r, sp - 16'h0001);
    chk("sp", {stack_pointer_high, stack_pointer_low}, sp - 16'h0002);
  endtask : ret_push

  // One instruction boundary; with a take, the whole entry is judged
  task bound(input logic take, input logic [11:0] vec);
    insn_done = 1'b1;
    tick();
    insn_done = 1'b0;
    sei = 1'b0;
    cli = 1'b0;
    return_from_interrupt = 1'b0;
    chk("take", irq_busy_r, {15'h0000, take});
    if (take) begin
      chk("gie_clr", gie_r, 16'h0000);
      ret_push(ret_pc, 16'h02ff);
      tick();
      chk("vec_valid", vec_valid_r, 16'h0001);
      chk("vec_addr", vec_addr_r, vec);
    end else begin
      // Strobes rest low over one edge before the next caller raises them
      tick();
    end
  endtask : bound

  ////////////////////////////////////////////////////////////
  // Scenarios
  task t_regs();
    wr_en = 1'b1;
    wr_addr = 5'h03;
    wr_data = 16'h0055;
    rd_a_addr = 5'h03;
    tick();
    chk("fwd", rd_a_data_r, 16'h0055);
    wr_wide = 1'b1;
    wr_addr = 5'h1e;
    wr_data = 16'h0180;
    tick();
    wr_en = 1'b0;
    wr_wide = 1'b0;
    rd_wide = 1'b1;
    rd_a_addr = 5'h1e;
    tick();
    chk("wide_lo", rd_a_data_r, 16'h0080);
    chk("wide_hi", rd_b_data_r, 16'h0001);
    rd_wide = 1'b0;
    ds_rd = 1'b1;
    ds_addr = 16'h001f;
    tick();
    chk("ds_hit", ds_hit_r, 16'h0001);
    chk("ds_data", ds_rdata_r, 16'h0001);
    ds_addr = 16'h0020;
    tick();
    chk("ds_miss", ds_hit_r, 16'h0000);
    ds_rd = 1'b0;
    ds_wr = 1'b1;
    ds_addr = 16'h0003;
    ds_wdata = 8'h77;
    rd_a_addr = 5'h03;
    tick();
    ds_wr = 1'b0;
    chk("ds_wr", rd_a_data_r, 16'h0077);
  endtask : t_regs

  // Back-to-back pointer modes on Z, each seeing the last update
  task automatic t_ptr();
    am_t modes [4] = '{AM_POSTINC, AM_PREDEC, AM_DISP, AM_PLAIN};
    logic [15:0] exp [4] = '{16'h0180, 16'h0180, 16'h0185, 16'h0180};
    ptr_go = 1'b1;
    ptr_disp = 6'h05;
    for (int i = 0; i < 4; i++) begin
      ptr_mode = modes[i];
      tick();
      chk("ptr", ptr_addr_r, exp[i]);
    end
    // X and Y from reset: post-increment and pre-decrement write back
    ptr_sel = PTR_X;
    ptr_mode = AM_POSTINC;
    tick();
    chk("ptr_x", ptr_addr_r, 16'h0000);
    ptr_sel = PTR_Y;
    ptr_mode = AM_PREDEC;
    tick();
    chk("ptr_y", ptr_addr_r, 16'hffff);
    ptr_go = 1'b0;
    rd_wide = 1'b1;
    rd_a_addr = 5'h1a;
    tick();
    chk("x_pair", {rd_b_data_r, rd_a_data_r}, 16'h0001);
    rd_a_addr = 5'h1c;
    tick();
    chk("y_pair", {rd_b_data_r, rd_a_data_r}, 16'hffff);
    rd_wide = 1'b0;
  endtask : t_ptr

  task t_stack();
    sp_high_wr = 1'b1;
    sp_wdata = 8'hff;
    tick();
    chk("sph_bits", stack_pointer_high, 16'h0003);
    sp_wdata = 8'h02;
    tick();
    sp_high_wr = 1'b0;
    sp_low_wr = 1'b1;
    sp_wdata = 8'hff;
    tick();
    sp_low_wr = 1'b0;
    stack_op = SOP_PUSH;
    push_data = 8'haa;
    tick();
    chk("push_we", stk_we_r, 16'h0001);
    chk("push_addr", stk_addr_r, 16'h02ff);
    chk("push_data", stk_wdata_r, 16'h00aa);
    chk("push_sp", stack_pointer_low, 16'h00fe);
    stack_op = SOP_POP;
    tick();
    chk("pop_rd", stk_rd_r, 16'h0001);
    chk("pop_addr", stk_addr_r, 16'h02ff);
    chk("pop_sp", stack_pointer_low, 16'h00ff);
    stack_op = SOP_CALL;
    tick();
    stack_op = SOP_NONE;
    chk("call_busy", irq_busy_r, 16'h0001);
    chk("pop_back", sram_rdata, 16'h00aa);
    ret_push(12'h123, 16'h02ff);
    stack_op = SOP_RET;
    tick();
    stack_op = SOP_NONE;
    chk("ret_addr", stk_addr_r, 16'h02fe);
    chk("ret_sp", stack_pointer_low, 16'h00ff);
  endtask : t_stack

  task t_irq();
    irq_event = 8'h05;
    tick();
    irq_event = 8'h00;
    chk("pend", irq_flags_r, 16'h0005);
    bound(1'b0, 12'h000);
    sei = 1'b1;
    bound(1'b0, 12'h000);
    bound(1'b1, 12'h001);
    chk("hw_clr", irq_flags_r, 16'h0004);
    return_from_interrupt = 1'b1;
    bound(1'b0, 12'h000);
    chk("return_from_interrupt_gie", gie_r, 16'h0001);
    vector_select_bit = 1'b1;
    bound(1'b1, 12'hc03);
    vector_select_bit = 1'b0;
    return_from_interrupt = 1'b1;
    bound(1'b0, 12'h000);
    irq_event = 8'h02;
    tick();
    irq_event = 8'h00;
    cli = 1'b1;
    bound(1'b0, 12'h000);
    flag_clr_wr = 1'b1;
    flag_clr_mask = 8'h02;
    tick();
    flag_clr_wr = 1'b0;
    chk("w1c", irq_flags_r, 16'h0000);
    // Software re-enable, the same path a nesting handler uses
    status_register_i_wr = 1'b1;
    status_register_i_wdata = 1'b1;
    irq_event = 8'h02;
    tick();
    status_register_i_wr = 1'b0;
    irq_event = 8'h00;
    chk("sw_gie", gie_r, 16'h0001);
    // Enable already on and a flag pending: sei, each boot lock and the disabled source block in turn, then the source is taken
    sei = 1'b1;
    bound(1'b0, 12'h000);
    boot_lock_bit_app = 1'b1;
    vector_select_bit = 1'b1;
    bound(1'b0, 12'h000);
    boot_lock_bit_app = 1'b0;
    vector_select_bit = 1'b0;
    boot_lock_bit_boot = 1'b1;
    pc_in_boot = 1'b1;
    bound(1'b0, 12'h000);
    boot_lock_bit_boot = 1'b0;
    pc_in_boot = 1'b0;
    irq_en = 8'hfd;
    bound(1'b0, 12'h000);
    irq_en = 8'hff;
    bound(1'b1, 12'h002);
    // Nested enable in the handler: the return boundary still never takes
    status_register_i_wr = 1'b1;
    irq_event = 8'h01;
    tick();
    status_register_i_wr = 1'b0;
    irq_event = 8'h00;
    return_from_interrupt = 1'b1;
    bound(1'b0, 12'h000);
    bound(1'b1, 12'h001);
    return_from_interrupt = 1'b1;
    bound(1'b0, 12'h000);
    // Level source that vanishes while disabled leaves nothing behind
    irq_en = 8'h7f;
    irq_level = 8'h80;
    tick();
    irq_level = 8'h00;
    irq_en = 8'hff;
    bound(1'b0, 12'h000);
    irq_level = 8'h80;
    bound(1'b1, 12'h008);
    irq_level = 8'h00;
  endtask : t_irq

  ////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    tick();
    chk("rst_spl", stack_pointer_low, 16'h00ff);
    chk("rst_sph", stack_pointer_high, 16'h0002);
    t_regs();
    t_ptr();
    t_stack();
    t_irq();
    wrap_up();
  end

  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule : cpu_regfile_stack_irq_tb
